// [cpurs_consts.vh]
// constants for the cpu register set: reset values, field positions, codes and offsets
`ifndef CPURS_CONSTS_VH
`define CPURS_CONSTS_VH
// reset values and vector addresses
`define CPURS_SP_RST 16'h00FF
`define CPURS_H_RST 8'h00
`define CPURS_VEC_HI_ADDR 16'hFFFE
`define CPURS_VEC_LO_ADDR 16'hFFFF
// condition flag bit positions
`define CPURS_CF_V 7
`define CPURS_CF_ONE6 6
`define CPURS_CF_ONE5 5
`define CPURS_CF_H 4
`define CPURS_CF_I 3
`define CPURS_CF_N 2
`define CPURS_CF_Z 1
`define CPURS_CF_C 0
// flag update classes
`define CPURS_FO_NONE 4'h0
`define CPURS_FO_ADD 4'h1
`define CPURS_FO_SUB 4'h2
`define CPURS_FO_LOGIC 4'h3
`define CPURS_FO_LOAD 4'h4
`define CPURS_FO_SHIFT 4'h5
`define CPURS_FO_BTST 4'h6
`define CPURS_FO_INCDEC 4'h7
`define CPURS_FO_DAA 4'h8
// lower index byte operations
`define CPURS_XO_NONE 4'h0
`define CPURS_XO_LOAD 4'h1
`define CPURS_XO_CLR 4'h2
`define CPURS_XO_INC 4'h3
`define CPURS_XO_DEC 4'h4
`define CPURS_XO_COM 4'h5
`define CPURS_XO_NEG 4'h6
`define CPURS_XO_LSL 4'h7
`define CPURS_XO_LSR 4'h8
`define CPURS_XO_ASR 4'h9
`define CPURS_XO_ROL 4'hA
`define CPURS_XO_ROR 4'hB
// debug register byte offsets
`define CPURS_OFF_CTRL 8'h00
`define CPURS_OFF_STAT 8'h04
`define CPURS_OFF_ACC 8'h08
`define CPURS_OFF_HX 8'h0C
`define CPURS_OFF_SP 8'h10
`define CPURS_OFF_PC 8'h14
`define CPURS_OFF_CF 8'h18
// control register fields
`define CPURS_CTRL_IRQ_HOLD 0
`define CPURS_CTRL_RST 1'h0
`endif

// [cpurs_dp_model.sv]
// reset vector responder standing in for program memory
`timescale 1ns/10ps
module cpurs_dp_model #(
  parameter logic [15:0] VECTOR = 16'h1234 // reset target held in memory
) (
  input wire logic ref_clk, // cpu bus clock
  input wire logic rst, // synchronous reset
  input wire logic vec_req, // vector byte wanted
  input wire logic [15:0] vec_addr, // vector byte address
  input wire logic [3:0] resp_delay, // idle cycles before each answer
  output logic vec_ack, // vector byte present
  output logic [7:0] vec_data // vector byte
);
  logic [3:0] wait_q;
  // data toggles outside the ack cycle so a stale byte can never pass for a good one
  always @(posedge ref_clk) begin
    if (rst || !vec_req) begin
      vec_ack <= 1'b0;
      wait_q <= 4'h0;
      vec_data <= rst ? 8'hA5 : ~vec_data;
    end else if (vec_ack || wait_q != resp_delay) begin
      vec_ack <= 1'b0;
      wait_q <= vec_ack ? 4'h0 : wait_q + 4'h1;
      vec_data <= ~vec_data;
    end else begin
      vec_ack <= 1'b1;
      vec_data <= vec_addr == 16'hFFFE ? VECTOR[15:8] : VECTOR[7:0];
    end
  end
endmodule // cpurs_dp_model

// [cpurs_flag_unit.v]
// condition flag update logic: overflow, nibble carry, msb set, result clear, borrow out
`timescale 1ns/10ps
module cpurs_flag_unit (
  input wire [3:0] fo, // flag update class
  input wire [15:0] res, // result, upper byte used when wide
  input wire wide, // result is a 16-bit value
  input wire c_in, // carry or borrow produced
  input wire h_in, // carry from bit 3 into bit 4
  input wire v_in, // two's complement overflow produced
  input wire [4:0] f_old, // present {v,h,n,z,c}
  output reg [4:0] f_new // next {v,h,n,z,c}
);
`include "cpurs_consts.vh"

  wire msb;
  wire zero;
  assign msb = wide ? res[15] : res[7];
  assign zero = wide ? (res == 16'h0000) : (res[7:0] == 8'h00);

  // each class touches only the flags it owns; the rest keep their value
  always @* begin
    f_new = f_old;
    case (fo)
      `CPURS_FO_ADD: f_new = {v_in, h_in, msb, zero, c_in};
      `CPURS_FO_SUB: f_new = {v_in, f_old[3], msb, zero, c_in};
      `CPURS_FO_LOGIC: f_new = {1'b0, f_old[3], msb, zero, f_old[0]};
      `CPURS_FO_LOAD: f_new = {1'b0, f_old[3], msb, zero, f_old[0]};
      `CPURS_FO_SHIFT: f_new = {msb ^ c_in, f_old[3], msb, zero, c_in};
      `CPURS_FO_BTST: f_new = {f_old[4:1], c_in};
      `CPURS_FO_INCDEC: f_new = {v_in, f_old[3], msb, zero, f_old[0]};
      `CPURS_FO_DAA: f_new = {f_old[4], f_old[3], msb, zero, c_in};
      default: f_new = f_old;
    endcase
  end
endmodule // cpurs_flag_unit

// [cpurs_regset.v]
// programmer-visible register set of the 8-bit cpu with a wishbone debug view
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/10ps
module cpurs_regset (
  input wire ref_clk, // cpu bus clock, 200 MHz
  input wire rst, // synchronous reset, active high
  // wishbone debug view, outside the cpu address space
  input wire wb_cyc_i, // bus cycle
  input wire wb_stb_i, // strobe
  input wire wb_we_i, // write enable
  input wire [7:0] wb_adr_i, // byte address
  input wire [3:0] wb_sel_i, // byte lanes
  input wire [31:0] wb_dat_i, // write data
  output reg [31:0] wb_dat_o, // read data
  output reg wb_ack_o, // acknowledge
  // reset vector fetch
  output wire vec_req, // vector byte read wanted
  output wire [15:0] vec_addr, // vector byte address
  input wire vec_ack, // vector byte present
  input wire [7:0] vec_data, // vector byte
  output wire core_ready, // vector loaded, execution may start
  // first result register
  input wire a_we, // load first result register
  input wire [7:0] a_din, // value for it
  output wire [7:0] a_q, // alu operand input
  // index pair
  input wire [3:0] x_op, // lower index byte operation
  input wire [7:0] x_din, // lower index byte load value
  input wire h_we, // load upper index byte
  input wire [7:0] h_din, // upper index byte value
  input wire hx_we, // load whole index pair
  input wire [15:0] hx_din, // index pair value
  input wire hx_inc, // post-increment of index pair
  output wire [15:0] index_base, // base pointer for indexed addressing
  // stack top pointer
  input wire sp_we, // load stack top pointer
  input wire [15:0] sp_din, // its value
  input wire sp_adj, // stack adjust by immediate
  input wire [7:0] sp_imm, // signed adjust amount
  input wire sp_low_rst, // stack low reset instruction
  input wire sp_push, // one byte pushed
  input wire sp_pull, // one byte pulled
  output wire [15:0] sp_addr, // next free stack location
  // program counter
  input wire pc_inc, // fetch advance
  input wire pc_load, // change of flow
  input wire [15:0] pc_target, // its target
  output wire [15:0] pc_addr, // next fetch address
  // alu result and flags
  input wire [3:0] alu_fo, // flag update class of alu result
  input wire [15:0] alu_res, // alu result
  input wire alu_wide, // result is 16 bits
  input wire alu_c, // carry or borrow from alu
  input wire alu_h, // carry from bit 3 from alu
  input wire alu_v, // overflow from alu
  input wire daa_op, // decimal adjust of first result register
  input wire cf_we, // transfer-to-flags instruction
  input wire [7:0] cf_din, // value for flags
  input wire mask_set, // set mask instruction
  input wire mask_clear_instr, // mask clear instruction
  output wire [7:0] condition_flags, // flag register as read
  // interrupts
  input wire irq_pending, // maskable request present
  input wire insn_boundary, // one-cycle pulse at each instruction boundary
  output wire irq_take, // start interrupt sequence now
  input wire [2:0] push_idx, // stack save step 0..4
  output reg [7:0] push_data, // byte for that step
  input wire push_done // last stack save written
);
`include "cpurs_consts.vh"

  localparam ST_VHI = 2'h0;
  localparam ST_VLO = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam [15:0] SP_RST_VAL = `CPURS_SP_RST;

  reg [1:0] st_q;
  reg [7:0] a_q_r;
  reg [7:0] h_q;
  reg [7:0] x_q;
  reg [15:0] sp_q;
  reg [15:0] pc_q;
  reg [4:0] fl_q;
  reg i_q;
  reg inhibit_q;
  reg ctrl_q;
  reg [7:0] vhi_q;
  wire [7:0] x_res;
  wire x_c;
  wire x_v;
  wire [3:0] x_fo;
  wire [4:0] fl_new;
  reg [3:0] fo_sel;
  reg [15:0] res_sel;
  reg wide_sel;
  reg c_sel;
  reg h_sel;
  reg v_sel;
  reg [7:0] daa_cor;
  reg daa_c;
  wire [7:0] daa_res;
  wire wb_req;
  reg [31:0] rd_d;

  ////////////////////////////////////////////////////////////////////////
  // reset vector fetch: high byte first, then low byte
  always @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_VHI;
    end else begin
      case (st_q)
        ST_VHI: if (vec_ack) st_q <= ST_VLO;
        ST_VLO: if (vec_ack) st_q <= ST_RUN;
        ST_RUN: st_q <= ST_RUN;
        default: st_q <= ST_VHI;
      endcase
    end
  end

  assign vec_req = (st_q != ST_RUN) && !rst;
  assign vec_addr = (st_q == ST_VHI) ? `CPURS_VEC_HI_ADDR : `CPURS_VEC_LO_ADDR;
  assign core_ready = (st_q == ST_RUN);

  // high vector byte waits here until the low byte completes the address
  always @(posedge ref_clk) begin
    if (st_q == ST_VHI && vec_ack) begin
      vhi_q <= vec_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // first result register; decimal adjust writes back into it
  always @* begin
    daa_cor = 8'h00;
    daa_c = fl_q[0];
    if (fl_q[3] || (a_q_r[3:0] > 4'h9)) begin
      daa_cor[3:0] = 4'h6;
    end
    if (fl_q[0] || (a_q_r > 8'h99)) begin
      daa_cor[7:4] = 4'h6;
      daa_c = 1'b1;
    end
  end

  assign daa_res = a_q_r + daa_cor;

  // no reset branch: contents survive reset
  always @(posedge ref_clk) begin
    if (daa_op) begin
      a_q_r <= daa_res;
    end else if (a_we) begin
      a_q_r <= a_din;
    end
  end

  assign a_q = a_q_r;

  ////////////////////////////////////////////////////////////////////////
  // index pair: upper byte cleared by reset, lower byte kept
  cpurs_x_unit u_x (
    .x_op(x_op),
    .x_cur(x_q),
    .x_din(x_din),
    .c_cur(fl_q[0]),
    .x_res(x_res),
    .x_c(x_c),
    .x_v(x_v),
    .x_fo(x_fo)
  );

  always @(posedge ref_clk) begin
    if (rst) begin
      h_q <= `CPURS_H_RST;
    end else if (hx_we) begin
      h_q <= hx_din[15:8];
    end else if (hx_inc) begin
      h_q <= h_q + {7'h00, (x_q == 8'hFF)};
    end else if (h_we) begin
      h_q <= h_din;
    end
  end

  // lower byte has no reset branch
  always @(posedge ref_clk) begin
    if (hx_we) begin
      x_q <= hx_din[7:0];
    end else if (hx_inc) begin
      x_q <= x_q + 8'h01;
    end else if (x_op != `CPURS_XO_NONE) begin
      x_q <= x_res;
    end
  end

  assign index_base = {h_q, x_q};

  ////////////////////////////////////////////////////////////////////////
  // stack top pointer; pushes go down, so it always names the free byte
  always @(posedge ref_clk) begin
    if (rst) begin
      sp_q <= `CPURS_SP_RST;
    end else if (sp_we) begin
      sp_q <= sp_din;
    end else if (sp_adj) begin
      sp_q <= sp_q + {{8{sp_imm[7]}}, sp_imm};
    end else if (sp_low_rst) begin
      sp_q <= {sp_q[15:8], SP_RST_VAL[7:0]};
    end else if (sp_push) begin
      sp_q <= sp_q - 16'h0001;
    end else if (sp_pull) begin
      sp_q <= sp_q + 16'h0001;
    end
  end

  assign sp_addr = sp_q;

  ////////////////////////////////////////////////////////////////////////
  // program counter: vector load at start, then fetch advance or jump
  always @(posedge ref_clk) begin
    if (st_q == ST_VLO && vec_ack) begin
      pc_q <= {vhi_q, vec_data};
    end else if (st_q == ST_RUN) begin
      if (pc_load) begin
        pc_q <= pc_target;
      end else if (pc_inc) begin
        pc_q <= pc_q + 16'h0001;
      end
    end
  end

  assign pc_addr = pc_q;

  ////////////////////////////////////////////////////////////////////////
  // flag source select: decimal adjust, then lower index op, then alu
  always @* begin
    fo_sel = alu_fo;
    res_sel = alu_res;
    wide_sel = alu_wide;
    c_sel = alu_c;
    h_sel = alu_h;
    v_sel = alu_v;
    if (daa_op) begin
      fo_sel = `CPURS_FO_DAA;
      res_sel = {8'h00, daa_res};
      wide_sel = 1'b0;
      c_sel = daa_c;
    end else if (x_fo != `CPURS_FO_NONE) begin
      fo_sel = x_fo;
      res_sel = {8'h00, x_res};
      wide_sel = 1'b0;
      c_sel = x_c;
      v_sel = x_v;
    end
  end

  cpurs_flag_unit u_flags (
    .fo(fo_sel),
    .res(res_sel),
    .wide(wide_sel),
    .c_in(c_sel),
    .h_in(h_sel),
    .v_in(v_sel),
    .f_old(fl_q),
    .f_new(fl_new)
  );

  // result flags carry no reset value; transfer-to-flags wins over results
  always @(posedge ref_clk) begin
    if (cf_we) begin
      fl_q <= {cf_din[`CPURS_CF_V], cf_din[`CPURS_CF_H], cf_din[`CPURS_CF_N],
               cf_din[`CPURS_CF_Z], cf_din[`CPURS_CF_C]};
    end else begin
      fl_q <= fl_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt mask; masked out of reset so no request lands before setup
  always @(posedge ref_clk) begin
    if (rst) begin
      i_q <= 1'b1;
    end else if (push_done || mask_set) begin
      i_q <= 1'b1;
    end else if (cf_we) begin
      i_q <= cf_din[`CPURS_CF_I];
    end else if (mask_clear_instr) begin
      i_q <= 1'b0;
    end
  end

  // one-boundary shadow after mask clear or flag transfer; set beats clear
  always @(posedge ref_clk) begin
    if (rst) begin
      inhibit_q <= 1'b0;
    end else if (mask_clear_instr || cf_we) begin
      inhibit_q <= 1'b1;
    end else if (insn_boundary) begin
      inhibit_q <= 1'b0;
    end
  end

  assign irq_take = irq_pending && !i_q && insn_boundary && !inhibit_q && core_ready
                    && !ctrl_q;

  // bits 6 and 5 are tied high and never stored
  assign condition_flags = {fl_q[4], 1'b1, 1'b1, fl_q[3], i_q, fl_q[2:0]};

  // stack save bytes in push order
  always @* begin
    case (push_idx)
      3'h0: push_data = pc_q[7:0];
      3'h1: push_data = pc_q[15:8];
      3'h2: push_data = x_q;
      3'h3: push_data = a_q_r;
      3'h4: push_data = condition_flags;
      default: push_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone debug view: one-cycle ack, unmapped reads give zero;
  // the cpu itself never reaches these through its address space
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always @* begin
    case (wb_adr_i)
      `CPURS_OFF_CTRL: rd_d = {31'h00000000, ctrl_q};
      `CPURS_OFF_STAT: rd_d = {27'h0000000, inhibit_q, i_q, core_ready, st_q};
      `CPURS_OFF_ACC: rd_d = {24'h000000, a_q_r};
      `CPURS_OFF_HX: rd_d = {16'h0000, h_q, x_q};
      `CPURS_OFF_SP: rd_d = {16'h0000, sp_q};
      `CPURS_OFF_PC: rd_d = {16'h0000, pc_q};
      `CPURS_OFF_CF: rd_d = {24'h000000, condition_flags};
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_q <= `CPURS_CTRL_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= wb_we_i ? 32'h00000000 : rd_d;
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == `CPURS_OFF_CTRL) begin
          ctrl_q <= wb_dat_i[`CPURS_CTRL_IRQ_HOLD];
        end
      end
    end
  end
endmodule // cpurs_regset

// [cpurs_regset_bench.sv]
// self-checking bench for the cpu register set
`timescale 1ns/10ps
module cpurs_regset_bench;
  logic ref_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00, a_din = 8'h00, x_din = 8'h00, h_din = 8'h00;
  logic [7:0] sp_imm = 8'h00, cf_din = 8'h00, vec_data, a_q, condition_flags, push_data;
  logic [3:0] wb_sel_i = 4'hF, x_op = 4'h0, alu_fo = 4'h0, resp_delay = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [15:0] hx_din = 16'h0, sp_din = 16'h0, pc_target = 16'h0, alu_res = 16'h0;
  logic [15:0] vec_addr, index_base, sp_addr, pc_addr;
  logic wb_ack_o, vec_req, vec_ack, core_ready, irq_take, h_we = 0, mask_set = 0;
  logic a_we = 0, hx_we = 0, hx_inc = 0, sp_we = 0, sp_adj = 0, sp_low_rst = 0, sp_push = 0;
  logic sp_pull = 0, pc_inc = 0, pc_load = 0, alu_wide = 0, alu_c = 0, alu_h = 0, alu_v = 0;
  logic daa_op = 0, cf_we = 0, mask_clear_instr = 0, irq_pending = 0, insn_boundary = 0;
  logic push_done = 0;
  logic [2:0] push_idx = 3'h7;
  // lower byte after each operation applied to 0x81 with borrow set
  logic [7:0] x_exp [2:11] = '{8'h00, 8'h82, 8'h80, 8'h7E, 8'h7F, 8'h02, 8'h40, 8'hC0, 8'h03,
    8'hC0};
  logic [7:0] push_exp [0:4] = '{8'h00, 8'h80, 8'hC0, 8'h47, 8'h60};
  int miscompares = 0, checks = 0;
  cpurs_regset cpurs_regset_i (.*);
  cpurs_dp_model cpurs_dp_model_i (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic stuck;
    miscompares++;
    end_of_test;
  endtask
  // drop every strobe after one sampled edge, then settle to mid cycle
  task automatic go;
    @(posedge ref_clk);
    a_we <= 0;
    h_we <= 0;
    sp_pull <= 0;
    mask_set <= 0;
    hx_we <= 0;
    hx_inc <= 0;
    sp_we <= 0;
    sp_adj <= 0;
    sp_low_rst <= 0;
    sp_push <= 0;
    pc_inc <= 0;
    pc_load <= 0;
    daa_op <= 0;
    cf_we <= 0;
    mask_clear_instr <= 0;
    insn_boundary <= 0;
    push_done <= 0;
    x_op <= 4'h0;
    alu_fo <= 4'h0;
    @(negedge ref_clk);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (core_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 100) stuck;
  endtask
  // classic single cycle; released only at the edge where ack is seen
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) stuck;
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
  endtask
  task automatic bound(input logic exp);
    @(posedge ref_clk);
    insn_boundary <= 1;
    @(negedge ref_clk);
    check("irq take", irq_take, exp);
    go;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    wait_ready;
    check("pc", pc_addr, 16'h1234);
    check("sp", sp_addr, 16'h00FF);
    check("h", index_base[15:8], 8'h00);
    check("ones", condition_flags[6:5], 2'h3);
    // post increment must carry into the upper byte
    @(posedge ref_clk);
    hx_we <= 1;
    hx_din <= 16'h00FF;
    a_we <= 1;
    a_din <= 8'h5A;
    go;
    @(posedge ref_clk);
    h_we <= 1;
    h_din <= 8'h12;
    go;
    check("hx", index_base, 16'h12FF);
    @(posedge ref_clk);
    hx_inc <= 1;
    go;
    check("hx", index_base, 16'h1300);
    check("a", a_q, 8'h5A);
    for (int i = 2; i < 12; i++) begin
      @(posedge ref_clk);
      x_op <= 4'h1;
      x_din <= 8'h81;
      cf_we <= 1;
      cf_din <= 8'h09;
      go;
      @(posedge ref_clk);
      x_op <= i[3:0];
      go;
      check("x", index_base, {8'h13, x_exp[i]});
    end
    @(posedge ref_clk);
    sp_we <= 1;
    sp_din <= 16'h01F0;
    go;
    @(posedge ref_clk);
    sp_adj <= 1;
    sp_imm <= 8'hFE;
    go;
    check("sp", sp_addr, 16'h01EE);
    @(posedge ref_clk);
    sp_adj <= 1;
    sp_imm <= 8'h7F;
    go;
    check("sp", sp_addr, 16'h026D);
    @(posedge ref_clk);
    sp_push <= 1;
    go;
    check("sp", sp_addr, 16'h026C);
    @(posedge ref_clk);
    sp_pull <= 1;
    go;
    check("sp", sp_addr, 16'h026D);
    @(posedge ref_clk);
    sp_low_rst <= 1;
    go;
    check("sp hi", sp_addr, 16'h02FF);
    // three back to back fetches, then a change of flow
    @(posedge ref_clk);
    pc_inc <= 1;
    repeat (2) @(posedge ref_clk);
    go;
    check("pc", pc_addr, 16'h1237);
    @(posedge ref_clk);
    pc_load <= 1;
    pc_target <= 16'h8000;
    go;
    check("pc", pc_addr, 16'h8000);
    @(posedge ref_clk);
    a_we <= 1;
    a_din <= 8'h41;
    alu_fo <= 4'h1;
    alu_res <= 16'h0041;
    alu_h <= 1;
    go;
    check("flags", condition_flags & 8'h97, 8'h10);
    @(posedge ref_clk);
    daa_op <= 1;
    go;
    check("daa", a_q, 8'h47);
    @(posedge ref_clk);
    alu_fo <= 4'h1;
    alu_res <= 16'h0000;
    alu_c <= 1;
    alu_h <= 0;
    alu_v <= 1;
    go;
    check("flags", condition_flags & 8'h97, 8'h83);
    @(posedge ref_clk);
    alu_fo <= 4'h2;
    alu_res <= 16'h0080;
    alu_c <= 0;
    alu_v <= 0;
    go;
    check("flags", condition_flags & 8'h87, 8'h04);
    // wide load: msb and zero come from all 16 bits
    @(posedge ref_clk);
    alu_fo <= 4'h4;
    alu_res <= 16'h0100;
    alu_wide <= 1;
    go;
    check("flags", condition_flags & 8'h87, 8'h00);
    @(posedge ref_clk);
    alu_wide <= 0;
    cf_we <= 1;
    cf_din <= 8'h00;
    irq_pending <= 1;
    go;
    check("flags", condition_flags, 8'h60);
    bound(0);
    bound(1);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      push_idx <= i[2:0];
      @(negedge ref_clk);
      check("push", push_data, push_exp[i]);
    end
    @(posedge ref_clk);
    push_idx <= 3'h7;
    push_done <= 1;
    go;
    check("mask", condition_flags[3], 1'b1);
    bound(0);
    @(posedge ref_clk);
    mask_clear_instr <= 1;
    go;
    bound(0);
    bound(1);
    @(posedge ref_clk);
    mask_set <= 1;
    go;
    check("mask", condition_flags[3], 1'b1);
    bound(0);
    wb(1, 8'h00, 32'h1, rd);
    wb(0, 8'h00, 32'h0, rd);
    check("ctrl", rd, 32'h1);
    wb(1, 8'h18, 32'hFF, rd);
    wb(0, 8'h18, 32'h0, rd);
    check("dbg flags", rd, 32'h68);
    wb(0, 8'h14, 32'h0, rd);
    check("dbg pc", rd, 32'h8000);
    wb(0, 8'h1C, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    // second reset with a slow vector answer
    @(posedge ref_clk);
    rst <= 1;
    resp_delay <= 4'h3;
    repeat (2) @(posedge ref_clk);
    rst <= 0;
    wait_ready;
    check("pc", pc_addr, 16'h1234);
    check("a", a_q, 8'h47);
    check("hx", index_base, 16'h00C0);
    check("sp", sp_addr, 16'h00FF);
    end_of_test;
  end
endmodule // cpurs_regset_bench

// [cpurs_regset_props.sv]
// port assertions for the cpu register set
`timescale 1ns/10ps
module cpurs_regset_props (
  input wire logic ref_clk, // cpu bus clock
  input wire logic rst, // synchronous reset
  input wire logic daa_op, cf_we, mask_clear_instr, push_done, // flag strobes
  input wire logic sp_we, sp_adj, sp_low_rst, pc_inc, pc_load, // pointer strobes
  input wire logic [7:0] sp_imm, a_q, push_data, condition_flags, // byte values
  input wire logic [3:0] x_op, alu_fo, // operation codes
  input wire logic [15:0] alu_res, sp_addr, pc_addr, index_base, vec_addr, // words
  input wire logic alu_wide, alu_c, alu_h, alu_v, core_ready, // alu status and core ready
  input wire logic insn_boundary, irq_take, vec_req, vec_ack, // handshakes
  input wire logic [2:0] push_idx // stack save step
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // expected values built from the present inputs; sp_step and f_exp are compared a cycle later through $past, push_exp in the same cycle
  wire logic [15:0] sp_step = sp_addr + {{8{sp_imm[7]}}, sp_imm};
  wire logic [4:0] f_exp = {alu_v, alu_h, alu_res[7], alu_res[7:0] == 8'h00, alu_c};
  wire logic [4:0] f_now = {condition_flags[7], condition_flags[4], condition_flags[2:0]};
  wire logic [7:0] push_exp = push_idx == 3'h0 ? pc_addr[7:0] : push_idx == 3'h1 ?
    pc_addr[15:8] : push_idx == 3'h2 ? index_base[7:0] : push_idx == 3'h3 ? a_q : condition_flags;
  // the unmask hold lasts until the next boundary, however far away it is
  logic hold_q;
  always @(posedge ref_clk) begin
    if (rst) hold_q <= 1'b0;
    else if (mask_clear_instr || cf_we) hold_q <= 1'b1;
    else if (insn_boundary) hold_q <= 1'b0;
  end
  // reset takes effect on the edge before rst is first seen low
  property p_sp_rst; $fell(rst) |-> sp_addr == 16'h00FF; endproperty
  a_sp_rst: assert property (p_sp_rst) else $error("stack pointer reset value");
  property p_h_rst; $fell(rst) |-> index_base[15:8] == 8'h00; endproperty
  a_h_rst: assert property (p_h_rst) else $error("upper index reset value");
  property p_ones; condition_flags[6:5] == 2'h3; endproperty
  a_ones: assert property (p_ones) else $error("fixed flag bits not one");
  property p_sp_adj; sp_adj && !sp_we |=> sp_addr == $past(sp_step); endproperty
  a_sp_adj: assert property (p_sp_adj) else $error("stack adjust sum");
  property p_sp_low; sp_low_rst && !sp_we && !sp_adj |=> (sp_addr >> 8) == ($past(sp_addr) >> 8);
  endproperty
  a_sp_low: assert property (p_sp_low) else $error("stack low reset hit high byte");
  property p_pc_inc; core_ready && pc_inc && !pc_load |=> pc_addr == $past(pc_addr) + 16'h0001;
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("fetch advance");
  // a plain 8-bit add with nothing of higher priority touching the flags
  property p_flags;
    alu_fo == 4'h1 && !alu_wide && !cf_we && !daa_op && x_op == 4'h0 |=> f_now == $past(f_exp);
  endproperty
  a_flags: assert property (p_flags)
    else $error("add flags");
  property p_irq_i; irq_take |-> !condition_flags[3]; endproperty
  a_irq_i: assert property (p_irq_i) else $error("interrupt taken while masked");
  property p_push; push_idx <= 3'h4 |-> push_data == push_exp; endproperty
  a_push: assert property (p_push) else $error("stack save byte order");
  property p_mask_set; push_done |=> condition_flags[3]; endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask not set after saves");
  property p_inhibit; hold_q && insn_boundary |-> !irq_take; endproperty
  a_inhibit: assert property (p_inhibit) else $error("interrupt right after unmask");
  property p_vec; vec_req && vec_ack && vec_addr == 16'hFFFE |=> vec_req && vec_addr == 16'hFFFF;
  endproperty
  a_vec: assert property (p_vec) else $error("vector byte order");
  c_irq: cover property (irq_take);
  c_daa: cover property (daa_op);
  c_vec: cover property (vec_ack && vec_addr == 16'hFFFF);
endmodule // cpurs_regset_props
bind cpurs_regset cpurs_regset_props cpurs_regset_props_i (.*);

// [cpurs_x_unit.v]
// operation unit for the lower index byte used as a general data register
`timescale 1ns/10ps
module cpurs_x_unit (
  input wire [3:0] x_op, // requested operation
  input wire [7:0] x_cur, // present lower byte
  input wire [7:0] x_din, // load value
  input wire c_cur, // present borrow out flag, for rotates
  output reg [7:0] x_res, // new lower byte
  output reg x_c, // carry produced
  output reg x_v, // overflow produced
  output reg [3:0] x_fo // flag update class
);
`include "cpurs_consts.vh"

  // one case per operation; flag class tells the flag unit what to touch
  always @* begin
    x_res = x_cur;
    x_c = c_cur;
    x_v = 1'b0;
    x_fo = `CPURS_FO_NONE;
    case (x_op)
      `CPURS_XO_LOAD: begin x_res = x_din; x_fo = `CPURS_FO_LOAD; end
      `CPURS_XO_CLR: begin x_res = 8'h00; x_c = 1'b0; x_fo = `CPURS_FO_LOGIC; end
      `CPURS_XO_INC: begin
        x_res = x_cur + 8'h01; x_v = (x_cur == 8'h7F); x_fo = `CPURS_FO_INCDEC;
      end
      `CPURS_XO_DEC: begin
        x_res = x_cur - 8'h01; x_v = (x_cur == 8'h80); x_fo = `CPURS_FO_INCDEC;
      end
      `CPURS_XO_COM: begin x_res = ~x_cur; x_c = 1'b1; x_fo = `CPURS_FO_SUB; end // V cleared
      `CPURS_XO_NEG: begin
        x_res = 8'h00 - x_cur; x_c = (x_cur != 8'h00); x_v = (x_cur == 8'h80);
        x_fo = `CPURS_FO_SUB;
      end
      `CPURS_XO_LSL: begin x_res = {x_cur[6:0], 1'b0}; x_c = x_cur[7]; x_fo = `CPURS_FO_SHIFT; end
      `CPURS_XO_LSR: begin x_res = {1'b0, x_cur[7:1]}; x_c = x_cur[0]; x_fo = `CPURS_FO_SHIFT; end
      `CPURS_XO_ASR: begin
        x_res = {x_cur[7], x_cur[7:1]}; x_c = x_cur[0]; x_fo = `CPURS_FO_SHIFT;
      end
      `CPURS_XO_ROL: begin x_res = {x_cur[6:0], c_cur}; x_c = x_cur[7]; x_fo = `CPURS_FO_SHIFT; end
      `CPURS_XO_ROR: begin x_res = {c_cur, x_cur[7:1]}; x_c = x_cur[0]; x_fo = `CPURS_FO_SHIFT; end
      default: x_fo = `CPURS_FO_NONE;
    endcase
  end
endmodule // cpurs_x_unit
